// ### mdsp_pkg.sv
// shared types and constants of the multi-mode multiply-add slice
`default_nettype none
package mdsp_pkg;
	// operand and lane widths
	localparam int A_W     = 19;   // a operand width
	localparam int B_W     = 18;   // b operand width
	localparam int ACC_W   = 48;   // full adder and result width
	localparam int SHIFT_W = 4;    // shifter amount width
	localparam int BF_W    = 16;   // bfloat16 word width
	localparam int NLANE   = 4;    // most lanes of any mode

	// timing: one clock of latency at 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int LATENCY_CYC   = 1;

	// reset values
	localparam logic [ACC_W-1:0] ACC_RST = 48'h0;

	// bfloat16 figures
	localparam int              BF_BIAS = 127;        // exponent bias
	localparam int              BF_POINT = 30;        // binary point of aligned sums
	localparam logic [7:0]      BF_EMAX = 8'hff;      // exponent of inf and nan
	localparam logic [BF_W-1:0] BF_NAN  = 16'h7fc0;   // quiet nan answer

	// modes, gray along normal, dual, quad
	typedef enum logic [1:0] {
		MDSP_NORMAL = 2'h0,
		MDSP_DUAL   = 2'h1,
		MDSP_QUAD   = 2'h3,
		MDSP_FLOAT  = 2'h2
	} mdsp_mode_type;

	// lane geometry indexed [mode code][lane]
	localparam int LANES [4]    = '{1, 2, 1, 4};
	localparam int A_OFF [4][4] = '{'{0,0,0,0}, '{0,11,0,0}, '{0,0,0,0}, '{0,7,11,15}};
	localparam int A_WID [4][4] = '{'{19,0,0,0}, '{11,8,0,0}, '{0,0,0,0}, '{7,4,4,4}};
	localparam int B_OFF [4][4] = '{'{0,0,0,0}, '{0,10,0,0}, '{0,0,0,0}, '{0,6,10,14}};
	localparam int B_WID [4][4] = '{'{18,0,0,0}, '{10,8,0,0}, '{0,0,0,0}, '{6,4,4,4}};
	localparam int L_OFF [4][4] = '{'{0,0,0,0}, '{0,24,0,0}, '{0,0,0,0}, '{0,12,24,36}};
	localparam int L_WID [4][4] = '{'{48,0,0,0}, '{24,24,0,0}, '{0,0,0,0}, '{12,12,12,12}};

	// static configuration of the slice
	typedef struct packed {
		mdsp_mode_type        mode;       // lane split
		logic                 signed_en;  // two's complement operands
		logic                 sub_en;     // subtract product from addend
		logic                 add_en;     // add the addend, else add zero
		logic                 acc_en;     // addend is the accumulator
		logic [SHIFT_W-1:0]   shift;      // right shift per lane
	} mdsp_cfg_type;

	// operands from fabric
	typedef struct packed {
		logic                 valid;      // operands present this cycle
		logic [A_W-1:0]       a;          // a data input
		logic [B_W-1:0]       b;          // b data input
		logic [ACC_W-1:0]     c;          // external addend
	} mdsp_opnd_type;

	// all state of the slice
	typedef struct packed {
		logic [ACC_W-1:0]     acc;        // unshifted lane sums
		logic [ACC_W-1:0]     result;     // shifted result
		logic                 valid;      // result present
	} mdsp_state_type;
endpackage : mdsp_pkg
`default_nettype wire

// ### mdsp_bf16_fma.sv
// bfloat16 fused multiply-add with a single final rounding
`default_nettype none
module mdsp_bf16_fma (
	input  wire logic [mdsp_pkg::BF_W-1:0] a,
	input  wire logic [mdsp_pkg::BF_W-1:0] b,
	input  wire logic [mdsp_pkg::BF_W-1:0] c,
	input  wire logic                      sub,
	output logic      [mdsp_pkg::BF_W-1:0] y
);
	import mdsp_pkg::*;

	logic               sp, sc, sbig, ssml, sgn;  // signs
	logic [7:0]         ea, eb, ec;               // biased exponents
	logic [7:0]         ma, mb, mc;               // mantissas with hidden bit
	logic               pz, cz, spec;             // zero and special flags
	logic signed [10:0] pe, ce, ebig, er;         // working exponents
	logic signed [10:0] d;                        // alignment distance
	logic [32:0]        xp, xc, big, sml, sum;    // aligned magnitudes
	logic [32:0]        norm;                     // normalised sum
	logic [8:0]         mr;                       // rounded mantissa
	logic               rnd;                      // round up
	int                 lead;                     // leading one position

	// exact product, alignment, one add, one rounding
	always_comb begin
		ea = a[14:7];
		eb = b[14:7];
		ec = c[14:7];
		ma = {1'b1, a[6:0]};
		mb = {1'b1, b[6:0]};
		mc = {1'b1, c[6:0]};
		pz = (ea == 8'h0) || (eb == 8'h0);   // subnormals flush to zero
		cz = (ec == 8'h0);
		spec = (ea == BF_EMAX) || (eb == BF_EMAX) || (ec == BF_EMAX);
		sp = a[15] ^ b[15] ^ sub;            // subtract flips product sign
		sc = c[15];
		pe = $signed({3'h0, ea}) + $signed({3'h0, eb}) - 11'(BF_BIAS);
		ce = $signed({3'h0, ec});
		xp = pz ? 33'h0 : {1'b0, 16'(ma * mb), 16'h0};   // no rounding here
		xc = cz ? 33'h0 : {2'h0, mc, 7'h0, 16'h0};
		if (pz)
			pe = ce;
		if (cz)
			ce = pe;
		// larger exponent sets the scale
		if (pe >= ce) begin
			big = xp;
			sml = xc;
			sbig = sp;
			ssml = sc;
			ebig = pe;
			d = pe - ce;
		end else begin
			big = xc;
			sml = xp;
			sbig = sc;
			ssml = sp;
			ebig = ce;
			d = ce - pe;
		end
		sml = (d > 11'sd32) ? 33'h0 : (sml >> d);
		// signed magnitude add
		if (sbig == ssml) begin
			sum = big + sml;
			sgn = sbig;
		end else if (big >= sml) begin
			sum = big - sml;
			sgn = sbig;
		end else begin
			sum = sml - big;
			sgn = ssml;
		end
		lead = 0;
		for (int i = 0; i < 33; i++) begin
			if (sum[i])
				lead = i;
		end
		er = ebig + 11'(lead) - 11'(BF_POINT);
		norm = sum << (32 - lead);
		// round to nearest even, the only rounding
		rnd = norm[24] & ((|norm[23:0]) | norm[25]);
		mr = {1'b0, 1'b1, norm[31:25]} + {8'h0, rnd};
		if (mr[8])
			er = er + 11'sd1;
		if (spec)
			y = BF_NAN;
		else if (sum == 33'h0)
			y = 16'h0;
		else if (er <= 11'sd0)
			y = {sgn, 15'h0};
		else if (er >= 11'sd255)
			y = {sgn, BF_EMAX, 7'h0};
		else
			y = {sgn, er[7:0], mr[8] ? 7'h0 : mr[6:0]};
	end
endmodule : mdsp_bf16_fma
`default_nettype wire

// ### mdsp_multiply_add.sv
// multi-mode multiply-add slice: integer lanes, bfloat16 fused path, shifter
`default_nettype none
module mdsp_multiply_add (
	input  wire logic                          clock,
	input  wire logic                          reset_n,
	input  wire mdsp_pkg::mdsp_cfg_type        cfg,
	input  wire mdsp_pkg::mdsp_opnd_type       opnd,
	output logic      [mdsp_pkg::ACC_W-1:0]    result,
	output logic                               result_valid
);
	import mdsp_pkg::*;

	mdsp_state_type     st_r;      // registered state
	mdsp_state_type     st_nxt;    // next state
	logic [ACC_W-1:0]   addend;    // lane addends, packed
	logic [BF_W-1:0]    fma_y;     // float path answer
	logic [ACC_W-1:0]   pa, pb;    // extended lane operands
	logic [ACC_W-1:0]   prod;      // lane product
	logic [ACC_W-1:0]   lsum;      // lane sum
	logic [ACC_W-1:0]   lsh;       // lane shifted
	logic [ACC_W-1:0]   sum_all;   // all lane sums
	logic [ACC_W-1:0]   shr_all;   // all shifted lanes
	int                 m;         // mode code as index

	// extend the low w bits to full width, sign or zero
	function automatic logic [ACC_W-1:0] ext(input logic [ACC_W-1:0] x,
			input int w, input logic sgn);
		logic [ACC_W-1:0] msk;
		msk = (w >= ACC_W) ? '1 : ((48'h1 << w) - 48'h1);
		ext = (sgn && x[w-1]) ? (x | ~msk) : (x & msk);
	endfunction : ext

	// addend is zero, external, or the accumulator
	assign addend = !cfg.add_en ? ACC_RST : (cfg.acc_en ? st_r.acc : opnd.c);

	// float path on the low 16 bits of each word
	mdsp_bf16_fma u_fma (
		.a   (opnd.a[BF_W-1:0]),
		.b   (opnd.b[BF_W-1:0]),
		.c   (addend[BF_W-1:0]),
		.sub (cfg.sub_en),
		.y   (fma_y)
	);

	// lane datapath and next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.valid = opnd.valid;
		m = int'(cfg.mode);
		pa = '0;
		pb = '0;
		prod = '0;
		lsum = '0;
		lsh = '0;
		sum_all = '0;
		shr_all = '0;
		if (cfg.mode == MDSP_FLOAT) begin
			// fused path, shifter not in use
			sum_all = {32'h0, fma_y};
			shr_all = sum_all;
		end else begin
			for (int i = 0; i < NLANE; i++) begin
				if (i < LANES[m]) begin
					// one signedness for every lane
					pa = ext(48'(opnd.a) >> A_OFF[m][i], A_WID[m][i], cfg.signed_en);
					pb = ext(48'(opnd.b) >> B_OFF[m][i], B_WID[m][i], cfg.signed_en);
					prod = pa * pb;
					lsum = ext(addend >> L_OFF[m][i], L_WID[m][i], cfg.signed_en);
					// adder or subtractor at lane width; quad 7x6 cut to 12
					lsum = cfg.sub_en ? lsum - prod : lsum + prod;
					lsum = ext(lsum, L_WID[m][i], cfg.signed_en);
					// per-lane right shift, arithmetic when signed
					if (cfg.signed_en)
						lsh = $unsigned($signed(lsum) >>> cfg.shift);
					else
						lsh = lsum >> cfg.shift;
					sum_all = sum_all | (ext(lsum, L_WID[m][i], 1'b0) << L_OFF[m][i]);
					shr_all = shr_all | (ext(lsh, L_WID[m][i], 1'b0) << L_OFF[m][i]);
				end
			end
		end
		if (opnd.valid) begin
			st_nxt.acc = sum_all;
			st_nxt.result = shr_all;
		end
	end

	// state register on the rising edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r.acc <= ACC_RST;
			st_r.result <= ACC_RST;
			st_r.valid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign result = st_r.result;
	assign result_valid = st_r.valid;

	// checks of lane arithmetic and timing
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_result_timing: assert property (opnd.valid |=> result_valid ##0 $stable(cfg.mode) [*1]
		or !$stable(cfg.mode)) else $error("valid operands gave no result");
	a_idle_no_result: assert property (!opnd.valid |=> !result_valid && $stable(result))
		else $error("result changed without operands");
	a_normal_signed: assert property (result_valid && $past(cfg.mode) == MDSP_NORMAL
		&& $past(cfg.signed_en) && !$past(cfg.add_en) && $past(cfg.shift) == 4'h0
		|-> $signed(result) == $signed($past(opnd.a)) * $signed($past(opnd.b)))
		else $error("signed 19x18 product wrong");
	a_normal_unsigned: assert property (result_valid && $past(cfg.mode) == MDSP_NORMAL
		&& !$past(cfg.signed_en) && !$past(cfg.add_en) && $past(cfg.shift) == 4'h0
		|-> result == $past(opnd.a) * $past(opnd.b))
		else $error("unsigned 19x18 product wrong");
	a_dual_lanes: assert property (result_valid && $past(cfg.mode) == MDSP_DUAL
		&& !$past(cfg.signed_en) && !$past(cfg.add_en) && $past(cfg.shift) == 4'h0
		|-> result[23:0] == $past(opnd.a[10:0]) * $past(opnd.b[9:0])
		&& result[47:24] == $past(opnd.a[18:11]) * $past(opnd.b[17:10]))
		else $error("dual lane product wrong");
	a_quad_trunc: assert property (result_valid && $past(cfg.mode) == MDSP_QUAD
		&& !$past(cfg.signed_en) && !$past(cfg.add_en) && $past(cfg.shift) == 4'h0
		|-> result[11:0] == 12'($past(opnd.a[6:0]) * $past(opnd.b[5:0]))
		&& result[47:36] == $past(opnd.a[18:15]) * $past(opnd.b[17:14]))
		else $error("quad lane product wrong");
	a_sub_addend: assert property (result_valid && $past(cfg.mode) == MDSP_NORMAL
		&& !$past(cfg.signed_en) && $past(cfg.add_en) && !$past(cfg.acc_en)
		&& $past(cfg.sub_en) && $past(cfg.shift) == 4'h0
		|-> result == 48'($past(opnd.c) - $past(opnd.a) * $past(opnd.b)))
		else $error("subtract from addend wrong");
	a_accumulate: assert property (opnd.valid && cfg.mode == MDSP_NORMAL && !cfg.signed_en
		&& cfg.add_en && cfg.acc_en && !cfg.sub_en
		|=> st_r.acc == 48'($past(st_r.acc) + $past(opnd.a) * $past(opnd.b)))
		else $error("accumulation wrong");
	a_shift_lane: assert property (result_valid && $past(cfg.mode) == MDSP_NORMAL
		&& !$past(cfg.signed_en) && !$past(cfg.add_en)
		|-> result == ($past(opnd.a) * $past(opnd.b)) >> $past(cfg.shift))
		else $error("right shift wrong");
	a_float_unit: assert property (opnd.valid && cfg.mode == MDSP_FLOAT && !cfg.add_en
		&& opnd.b[15:0] == 16'h3f80 && opnd.a[14:7] != 8'h0 && opnd.a[14:7] != 8'hff
		|=> result == {32'h0, $past(opnd.a[15:0])})
		else $error("float multiply by one changed value");

	// float answer sits in the low 16 bits only
	a_float_upper: assert property (result_valid && $past(cfg.mode) == MDSP_FLOAT
		|-> result[47:16] == 32'h0)
		else $error("float result upper bits not zero");
	// accumulator untouched while no operands arrive
	a_acc_hold: assert property (!opnd.valid |=> st_r.acc == $past(st_r.acc))
		else $error("accumulator changed without operands");

	c_normal_mac: cover property (opnd.valid && cfg.mode == MDSP_NORMAL && cfg.add_en ##1
		result_valid);
	c_dual_shift: cover property (opnd.valid && cfg.mode == MDSP_DUAL && cfg.shift != 4'h0);
	c_quad_signed: cover property (opnd.valid && cfg.mode == MDSP_QUAD && cfg.signed_en);
	c_float_acc: cover property (opnd.valid && cfg.mode == MDSP_FLOAT && cfg.acc_en
		[*2]);
endmodule : mdsp_multiply_add
`default_nettype wire

// ### mdsp_fabric_src.sv
// operand source standing in for the fabric user logic
`default_nettype none
module mdsp_fabric_src (
	input  wire logic                  clock,
	output var  mdsp_pkg::mdsp_cfg_type  cfg,
	output var  mdsp_pkg::mdsp_opnd_type opnd
);
	import mdsp_pkg::*;

	// quiet start: no operands, plain configuration
	initial begin
		cfg  = '0;
		opnd = '0;
	end

	// present one operand set on the falling edge
	task automatic send(input mdsp_cfg_type c_cfg, input logic [A_W-1:0] a,
		input logic [B_W-1:0] b, input logic [ACC_W-1:0] c);
		@(negedge clock);
		cfg  <= c_cfg;
		opnd <= '{1'b1, a, b, c};
	endtask : send

	// release operands; data lines flip so stale values are never trusted
	task automatic idle();
		@(negedge clock);
		opnd.valid <= 1'b0;
		opnd.a     <= ~opnd.a;
		opnd.b     <= ~opnd.b;
		opnd.c     <= ~opnd.c;
	endtask : idle
endmodule : mdsp_fabric_src
`default_nettype wire

// ### mdsp_multiply_add_test.sv
// self-checking bench of the multi-mode multiply-add slice
`default_nettype none
module mdsp_multiply_add_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mdsp_pkg::*;

	// one table row: controls are signed, sub, add, acc
	typedef struct packed {
		mdsp_mode_type    mode;   // lane split
		logic [3:0]       ctl;    // signed, sub, add, acc
		logic [3:0]       shift;  // right shift
		logic [A_W-1:0]   a;      // a operand
		logic [B_W-1:0]   b;      // b operand
		logic [ACC_W-1:0] c;      // addend
		logic [ACC_W-1:0] want;   // expected result
	} mdsp_row_type;

	logic             clock;         // fabric clock
	logic             reset_n;       // async reset
	mdsp_cfg_type     cfg;           // slice setup
	mdsp_opnd_type    opnd;          // operands
	logic [ACC_W-1:0] result;        // slice result
	logic             result_valid;  // result strobe
	int               err_count;     // mismatches
	int               checks;        // comparisons
	int               cycles;        // timeout count
	logic [ACC_W-1:0] acc_want [4] = '{48'h7, 48'hf, 48'h16, 48'h1e};  // running sums >> 1

	// ordinary cases
	mdsp_row_type rows [16] = '{
		'{MDSP_NORMAL, 4'b0010, 4'h0, 19'h00003, 18'h00005, 48'h10, 48'h1f},
		'{MDSP_NORMAL, 4'b1110, 4'h1, 19'h7fffe, 18'h00003, 48'h20, 48'h13},
		'{MDSP_NORMAL, 4'b1000, 4'h0, 19'h3ffff, 18'h1ffff, 48'h1234, 48'h7fffa0001},
		'{MDSP_NORMAL, 4'b0000, 4'h0, 19'h7ffff, 18'h3ffff, 48'h0, 48'h1ffff40001},
		'{MDSP_DUAL, 4'b0010, 4'h0, 19'h7ffff, 18'h3ffff, 48'h1, 48'h00fe011ff402},
		'{MDSP_DUAL, 4'b1010, 4'h4, 19'h40400, 18'h00600, 48'h0, 48'hfffff8008000},
		'{MDSP_QUAD, 4'b0000, 4'h0, 19'h097ff, 18'h04fff, 48'h0, 48'h0010060e1f41},
		'{MDSP_QUAD, 4'b0000, 4'h4, 19'h097ff, 18'h04fff, 48'h0, 48'h00000000e0f4},
		'{MDSP_QUAD, 4'b0110, 4'h0, 19'h097ff, 18'h04fff, 48'h0, 48'hfffffaf1f0bf},
		'{MDSP_FLOAT, 4'b0010, 4'h0, 19'h03fc0, 18'h04000, 48'h3f80, 48'h4080},
		'{MDSP_FLOAT, 4'b0110, 4'h0, 19'h03fc0, 18'h04000, 48'h3f80, 48'hc000},
		'{MDSP_FLOAT, 4'b0010, 4'h0, 19'h07f80, 18'h04000, 48'h3f80, 48'h7fc0},
		'{MDSP_FLOAT, 4'b0010, 4'h0, 19'h03f81, 18'h03f81, 48'hbf82, 48'h3880},
		'{MDSP_NORMAL, 4'b0110, 4'h0, 19'h00003, 18'h00005, 48'h100, 48'hf1},
		'{MDSP_DUAL, 4'b0000, 4'h0, 19'h7ffff, 18'h3ffff, 48'h1, 48'h00fe011ff401},
		'{MDSP_FLOAT, 4'b0000, 4'h0, 19'h03fc0, 18'h03f80, 48'h0, 48'h3fc0}
	};

	mdsp_fabric_src u_mdsp_fabric_src (.clock(clock), .cfg(cfg), .opnd(opnd));

	mdsp_multiply_add u_mdsp_multiply_add (
		.clock        (clock),
		.reset_n      (reset_n),
		.cfg          (cfg),
		.opnd         (opnd),
		.result       (result),
		.result_valid (result_valid)
	);

	// free-running 250 MHz clock
	initial clock = 1'b0;
	always #2 clock = ~clock;

	// compare and count
	task automatic check(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] want);
		checks++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// counts, verdict, end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// hang guard, far above the few dozen cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			err_count++;
			give_verdict();
		end
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		repeat (5) @(posedge clock);
		#1;
		check(result, 48'h0);
		@(negedge clock);
		reset_n = 1'b1;
		// table rows back to back, one per cycle
		foreach (rows[i]) begin
			u_mdsp_fabric_src.send({rows[i].mode, rows[i].ctl, rows[i].shift},
				rows[i].a, rows[i].b, rows[i].c);
			@(posedge clock);
			#1;
			check(result, rows[i].want);
			check({47'h0, result_valid}, 48'h1);
		end
		// no operands: strobe drops, result holds
		u_mdsp_fabric_src.idle();
		@(posedge clock);
		#1;
		check({47'h0, result_valid}, 48'h0);
		check(result, rows[15].want);
		// reset in mid-run clears without a clock edge
		@(negedge clock);
		reset_n = 1'b0;
		#1;
		check(result, 48'h0);
		check({47'h0, result_valid}, 48'h0);
		@(negedge clock);
		reset_n = 1'b1;
		// accumulate 3*5 with a gap before the last step
		foreach (acc_want[i]) begin
			if (i == 3) begin
				u_mdsp_fabric_src.idle();
				@(posedge clock);
				#1;
				check(result, acc_want[2]);
			end
			u_mdsp_fabric_src.send({MDSP_NORMAL, 4'b0011, 4'h1}, 19'h3, 18'h5, 48'h1234);
			@(posedge clock);
			#1;
			check(result, acc_want[i]);
		end
		give_verdict();
	end
endmodule : mdsp_multiply_add_test
`default_nettype wire
